// [rtl/memio_pkg.sv]
// Constants, field layouts and carrier types for the memory I/O element.
// Assumes a single 10 MHz clock; every path is modelled as whole-cycle stages.
//
// What this block does
// - Input path is capture, resync and half-rate stages, each one bypassable.
// - Capture stage has rising, falling and pair-aligning registers.
// - Capture registers use a shared clock or true and inverted strobes.
// - Alignment register runs on the system clock every cycle, not gated by the strobes.
// - Up to three resync levels, clocked from the system or the read-leveling tap.
// - Resynced data goes straight to core or into the half-rate converter.
// - Run-time data-out bypass picks direct data or half-rate converter output.
// - Output-register bypass picks second mux or fourth alignment register.
// - Output path has half-rate, resync and output stages; SDR and DDR modes.
// - Half-rate core data is converted to full rate by the divided clock.
// - Output resync on system clock; third-generation mode adds leveling registers.
// - Data write phase sits 45 degrees from strobe write phase, moved further by the data-out phase setting.
// - Output-enable path mirrors output path latency exactly.
// - Delay chains take run-time settings from the configuration chains.
// - Two output, one input, two enable and two termination delay chains.
// - Strobe block delays its bus output and its enable input.
// - Configuration chains clear to zero at reset.
// - One I/O chain per pin plus one strobe chain per strobe pin.
// - I/O chain layout: out delay one, out delay two, input delay.
// - Strobe chain bits 0 to 23: delays and phase settings.
// - Strobe chain bits 24 to 36: cycle delays, enable and termination delays.
// - Strobe chain bits 37 to 45: bypass, transfer registers, phase inverts.
package memio_pkg;

   // Register byte offsets
   localparam logic [4:0] CTRL_OFS = 5'h00;
   localparam logic [4:0] SHIFT_OFS = 5'h04;
   localparam logic [4:0] UPDATE_OFS = 5'h08;
   localparam logic [4:0] IO_APPLIED_OFS = 5'h0c;
   localparam logic [4:0] STROBE_LO_OFS = 5'h10;
   localparam logic [4:0] STROBE_HI_OFS = 5'h14;

   // Field positions in the shift register and control words
   localparam int SHIFT_BIT_POS = 0;
   localparam int SHIFT_SEL_POS = 1;
   localparam int UPDATE_POS = 0;
   localparam int IO_CHAIN_LEN = 11;
   localparam int STROBE_CHAIN_LEN = 46;
   localparam int CTRL_W = 10;

   // Reset values
   localparam logic [9:0] CTRL_RST = 10'h000;
   localparam logic [10:0] IO_CHAIN_RST = 11'h000;
   localparam logic [45:0] STROBE_CHAIN_RST = 46'h0000_0000_0000;

   // Delay line depth and the 45 degree write offset in 22.5 degree steps
   localparam int DLY_DEPTH = 16;
   localparam logic [3:0] WRITE_PHASE_OFFSET = 4'h2;
   localparam logic [3:0] HALF_TURN = 4'h8;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {OUT_SDR_COMB, OUT_SDR_REG, OUT_DDR_FULL, OUT_DDR_HALF} out_mode_e;

   typedef struct packed {
      logic out_resync_en;
      logic ddr3_leveling;
      out_mode_e out_mode;
      logic out_reg_bypass;
      logic resync_from_leveling;
      logic [1:0] resync_levels;
      logic in_ddr_bypass;
      logic capture_strobe_mode;
   } ctrl_s;

   // Bit 0 of the chain is the last field listed
   typedef struct packed {
      logic [3:0] in_delay;
      logic [2:0] out_delay_two;
      logic [3:0] out_delay_one;
   } io_cfg_s;

   typedef struct packed {
      logic strobe_out_phase_inv;
      logic dq_out_phase_inv;
      logic en_ctrl_phase_inv;
      logic resync_phase_inv;
      logic in_xfer_en;
      logic out_xfer_en;
      logic term_xfer_en;
      logic strobe_en_xfer_en;
      logic dataout_bypass;
      logic [2:0] term_delay_two;
      logic [3:0] term_delay_one;
      logic [2:0] strobe_en_delay;
      logic out_cycle_dly;
      logic in_cycle_dly;
      logic term_cycle_dly;
      logic divider_phase;
      logic [3:0] resync_phase;
      logic [3:0] dq_out_phase;
      logic [3:0] strobe_out_phase;
      logic [3:0] en_ctrl_phase;
      logic [2:0] in_phase;
      logic [3:0] busout_delay;
   } strobe_cfg_s;

endpackage

// [rtl/memio_element.sv]
// One memory I/O element: input, output and enable register paths, delay
// chains and the serial configuration chains, with an AXI4-Lite slave.
// Assumes all pin-side inputs are synchronous to aclk; a DDR pin is carried
// as a rise and fall sample pair per clock.
//
// Implementation choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module memio_element (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic awvalid,
   output logic awready,
   input wire logic [4:0] awaddr,
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   input wire logic arvalid,
   output logic arready,
   input wire logic [4:0] araddr,
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   input wire logic pad_rise,
   input wire logic pad_fall,
   input wire logic strobe_true,
   input wire logic strobe_comp,
   input wire logic [3:0] core_wdata,
   input wire logic [3:0] core_oe,
   input wire logic core_term_en,
   input wire logic core_strobe_en,
   output logic [3:0] core_rdata,
   output logic pad_out_rise,
   output logic pad_out_fall,
   output logic pad_oe_rise,
   output logic pad_oe_fall,
   output logic term_en_out,
   output logic [1:0] strobe_busout,
   output logic strobe_en_dly,
   output logic [3:0] dq_write_phase,
   output logic [3:0] strobe_write_phase
);

   localparam int NCH = 9;

   // Bus-side state
   logic [4:0] aw_addr_q;
   logic aw_full_q;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;
   logic w_full_q;
   memio_pkg::ctrl_s ctrl_q;
   logic [10:0] io_chain_q;
   logic [45:0] strobe_chain_q;
   memio_pkg::io_cfg_s io_cfg_q;
   memio_pkg::strobe_cfg_s strobe_cfg_q;

   // Write decode: a write executes once address and data are both held
   logic wr_go;
   logic wr_ctrl;
   logic wr_shift;
   logic wr_update;
   logic wr_hit;
   logic [9:0] ctrl_wr_val;
   assign wr_go = aw_full_q && w_full_q && !bvalid;
   assign wr_ctrl = wr_go && (aw_addr_q == memio_pkg::CTRL_OFS);
   assign wr_shift = wr_go && (aw_addr_q == memio_pkg::SHIFT_OFS) && w_strb_q[0];
   assign wr_update = wr_go && (aw_addr_q == memio_pkg::UPDATE_OFS) && w_strb_q[0]
                      && w_data_q[memio_pkg::UPDATE_POS];
   assign wr_hit = (aw_addr_q == memio_pkg::CTRL_OFS) || (aw_addr_q == memio_pkg::SHIFT_OFS)
                   || (aw_addr_q == memio_pkg::UPDATE_OFS);
   assign ctrl_wr_val = {w_strb_q[1] ? w_data_q[9:8] : ctrl_q[9:8],
                         w_strb_q[0] ? w_data_q[7:0] : ctrl_q[7:0]};

   // Write channels: address and data are taken in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready <= 1'b1;
         wready <= 1'b1;
         aw_full_q <= 1'b0;
         w_full_q <= 1'b0;
         aw_addr_q <= 5'h00;
         w_data_q <= 32'h0000_0000;
         w_strb_q <= 4'h0;
         bvalid <= 1'b0;
         bresp <= memio_pkg::RESP_OKAY;
      end else begin
         if (awvalid && awready) begin
            aw_addr_q <= awaddr;
            aw_full_q <= 1'b1;
            awready <= 1'b0;
         end
         if (wvalid && wready) begin
            w_data_q <= wdata;
            w_strb_q <= wstrb;
            w_full_q <= 1'b1;
            wready <= 1'b0;
         end
         if (wr_go) begin
            bvalid <= 1'b1;
            bresp <= wr_hit ? memio_pkg::RESP_OKAY : memio_pkg::RESP_SLVERR;
         end
         if (bvalid && bready) begin
            bvalid <= 1'b0;
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            awready <= 1'b1;
            wready <= 1'b1;
         end
      end
   end

   // Read decode; write-only registers read as zero
   logic rd_hit;
   logic [31:0] rd_val;
   assign rd_hit = (araddr == memio_pkg::CTRL_OFS) || (araddr == memio_pkg::SHIFT_OFS)
                   || (araddr == memio_pkg::UPDATE_OFS) || (araddr == memio_pkg::IO_APPLIED_OFS)
                   || (araddr == memio_pkg::STROBE_LO_OFS) || (araddr == memio_pkg::STROBE_HI_OFS);
   assign rd_val = (araddr == memio_pkg::CTRL_OFS) ? {22'h00_0000, ctrl_q} :
                   (araddr == memio_pkg::IO_APPLIED_OFS) ? {21'h00_0000, io_cfg_q} :
                   (araddr == memio_pkg::STROBE_LO_OFS) ? strobe_cfg_q[31:0] :
                   (araddr == memio_pkg::STROBE_HI_OFS) ? {18'h0_0000, strobe_cfg_q[45:32]} :
                   32'h0000_0000;

   // Read channel: one read in flight, answered the cycle after acceptance
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b1;
         rvalid <= 1'b0;
         rdata <= 32'h0000_0000;
         rresp <= memio_pkg::RESP_OKAY;
      end else if (arvalid && arready) begin
         arready <= 1'b0;
         rvalid <= 1'b1;
         rdata <= rd_val;
         rresp <= rd_hit ? memio_pkg::RESP_OKAY : memio_pkg::RESP_SLVERR;
      end else if (rvalid && rready) begin
         rvalid <= 1'b0;
         arready <= 1'b1;
      end
   end

   // Control register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_q <= memio_pkg::ctrl_s'(memio_pkg::CTRL_RST);
      end else if (wr_ctrl) begin
         ctrl_q <= memio_pkg::ctrl_s'(ctrl_wr_val);
      end
   end

   // Serial chains take one bit per write, entering at the top so the first
   // bit shifted ends in bit 0; the applied copy only moves on update
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         io_chain_q <= memio_pkg::IO_CHAIN_RST;
         strobe_chain_q <= memio_pkg::STROBE_CHAIN_RST;
         io_cfg_q <= memio_pkg::io_cfg_s'(memio_pkg::IO_CHAIN_RST);
         strobe_cfg_q <= memio_pkg::strobe_cfg_s'(memio_pkg::STROBE_CHAIN_RST);
      end else begin
         if (wr_shift && !w_data_q[memio_pkg::SHIFT_SEL_POS]) begin
            io_chain_q <= {w_data_q[memio_pkg::SHIFT_BIT_POS], io_chain_q[10:1]};
         end
         if (wr_shift && w_data_q[memio_pkg::SHIFT_SEL_POS]) begin
            strobe_chain_q <= {w_data_q[memio_pkg::SHIFT_BIT_POS], strobe_chain_q[45:1]};
         end
         if (wr_update) begin
            io_cfg_q <= memio_pkg::io_cfg_s'(io_chain_q);
            strobe_cfg_q <= memio_pkg::strobe_cfg_s'(strobe_chain_q);
         end
      end
   end

   // Divided-down clock phase, reloaded from the divider phase bit on update
   logic div_q;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         div_q <= 1'b0;
      end else if (wr_update) begin
         div_q <= strobe_chain_q[23];
      end else begin
         div_q <= !div_q;
      end
   end

   // Delay chain inputs, settings and taps
   logic [1:0] dl_in [NCH];
   logic [1:0] dl_out [NCH];
   logic [3:0] dl_sel [NCH];
   logic [1:0] lane_out [2];

   // Output data and enable each pass two chains in series; termination too
   assign dl_in[0] = lane_out[0];
   assign dl_in[1] = dl_out[0];
   assign dl_in[2] = {pad_fall, pad_rise};
   assign dl_in[3] = lane_out[1];
   assign dl_in[4] = dl_out[3];
   assign dl_in[5] = {1'b0, core_term_en};
   assign dl_in[6] = dl_out[5];
   assign dl_in[7] = {strobe_comp, strobe_true};
   assign dl_in[8] = {1'b0, core_strobe_en};
   // Enable chains share the data settings so enable never drifts from data
   assign dl_sel[0] = io_cfg_q.out_delay_one;
   assign dl_sel[1] = {1'b0, io_cfg_q.out_delay_two};
   assign dl_sel[2] = io_cfg_q.in_delay;
   assign dl_sel[3] = io_cfg_q.out_delay_one;
   assign dl_sel[4] = {1'b0, io_cfg_q.out_delay_two};
   assign dl_sel[5] = strobe_cfg_q.term_delay_one;
   assign dl_sel[6] = {1'b0, strobe_cfg_q.term_delay_two};
   assign dl_sel[7] = strobe_cfg_q.busout_delay;
   assign dl_sel[8] = {1'b0, strobe_cfg_q.strobe_en_delay};

   // Each chain is a tapped line; setting zero still costs one register
   for (genvar c = 0; c < NCH; c++) begin : g_dly
      logic [1:0] line_q [memio_pkg::DLY_DEPTH];
      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            for (int i = 0; i < memio_pkg::DLY_DEPTH; i++) begin
               line_q[i] <= 2'h0;
            end
         end else begin
            line_q[0] <= dl_in[c];
            for (int i = 1; i < memio_pkg::DLY_DEPTH; i++) begin
               line_q[i] <= line_q[i-1];
            end
         end
      end
      assign dl_out[c] = line_q[dl_sel[c]];
   end

   // Capture stage: strobe mode holds each register while its strobe is low
   logic cap_rise_q;
   logic cap_fall_q;
   logic [1:0] align_q;
   logic [1:0] cap_out;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cap_rise_q <= 1'b0;
         cap_fall_q <= 1'b0;
         align_q <= 2'h0;
      end else begin
         if (!ctrl_q.capture_strobe_mode || strobe_true) begin
            cap_rise_q <= dl_out[2][0];
         end
         if (!ctrl_q.capture_strobe_mode || strobe_comp) begin
            cap_fall_q <= dl_out[2][1];
         end
         align_q <= {cap_fall_q, cap_rise_q};
      end
   end
   assign cap_out = ctrl_q.in_ddr_bypass ? dl_out[2] : align_q;

   // Resync levels; the leveling source adds the read-leveling tap register
   logic [1:0] lvl_q;
   logic [1:0] rs_q [3];
   logic [1:0] rs_src;
   logic [1:0] rs_out;
   assign rs_src = ctrl_q.resync_from_leveling ? lvl_q : cap_out;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         lvl_q <= 2'h0;
         for (int i = 0; i < 3; i++) begin
            rs_q[i] <= 2'h0;
         end
      end else begin
         lvl_q <= cap_out;
         rs_q[0] <= rs_src;
         for (int i = 1; i < 3; i++) begin
            rs_q[i] <= rs_q[i-1];
         end
      end
   end
   assign rs_out = (ctrl_q.resync_levels == 2'h0) ? rs_src : rs_q[ctrl_q.resync_levels - 2'h1];

   // Half-rate conversion of input: first pair low, second pair high
   logic [1:0] hr_lo_q;
   logic [3:0] hr_word_q;
   logic [3:0] in_mux2;
   logic [3:0] align4_q;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         hr_lo_q <= 2'h0;
         hr_word_q <= 4'h0;
         align4_q <= 4'h0;
         core_rdata <= 4'h0;
      end else begin
         if (!div_q) begin
            hr_lo_q <= rs_out;
         end else begin
            hr_word_q <= {rs_out, hr_lo_q};
         end
         align4_q <= in_mux2;
         core_rdata <= ctrl_q.out_reg_bypass ? in_mux2 : align4_q;
      end
   end
   assign in_mux2 = strobe_cfg_q.dataout_bypass ? {2'h0, rs_out} : hr_word_q;

   // Output and enable lanes share one structure so their latency is equal
   for (genvar l = 0; l < 2; l++) begin : g_lane
      logic [3:0] word;
      logic [3:0] hold_q;
      logic [1:0] conv;
      logic [1:0] rsy_q;
      logic [1:0] lev_q;
      logic [1:0] oreg_q;
      logic [1:0] pre_lev;
      logic [1:0] post_lev;
      assign word = (l == 0) ? core_wdata : core_oe;
      assign conv = (ctrl_q.out_mode == memio_pkg::OUT_DDR_HALF) ? (div_q ? hold_q[3:2] : word[1:0]) :
                    (ctrl_q.out_mode == memio_pkg::OUT_DDR_FULL) ? word[1:0] :
                    {word[0], word[0]};
      assign pre_lev = ctrl_q.out_resync_en ? rsy_q : conv;
      assign post_lev = ctrl_q.ddr3_leveling ? lev_q : pre_lev;
      assign lane_out[l] = (ctrl_q.out_mode == memio_pkg::OUT_SDR_COMB) ? post_lev : oreg_q;
      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            hold_q <= 4'h0;
            rsy_q <= 2'h0;
            lev_q <= 2'h0;
            oreg_q <= 2'h0;
         end else begin
            if (!div_q) begin
               hold_q <= word;
            end
            rsy_q <= conv;
            lev_q <= pre_lev;
            oreg_q <= post_lev;
         end
      end
   end

   // Write phases: strobe phase plus optional half turn, data 45 degrees ahead plus dq_out_phase
   logic [3:0] strobe_phase;
   assign strobe_phase = strobe_cfg_q.strobe_out_phase
                         + (strobe_cfg_q.strobe_out_phase_inv ? memio_pkg::HALF_TURN : 4'h0);

   // Pin-facing flops keep every output glitch-free from a register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pad_out_rise <= 1'b0;
         pad_out_fall <= 1'b0;
         pad_oe_rise <= 1'b0;
         pad_oe_fall <= 1'b0;
         term_en_out <= 1'b0;
         strobe_busout <= 2'h0;
         strobe_en_dly <= 1'b0;
         dq_write_phase <= 4'h0;
         strobe_write_phase <= 4'h0;
      end else begin
         pad_out_rise <= dl_out[1][0];
         pad_out_fall <= dl_out[1][1];
         pad_oe_rise <= dl_out[4][0];
         pad_oe_fall <= dl_out[4][1];
         term_en_out <= dl_out[6][0];
         strobe_busout <= dl_out[7];
         strobe_en_dly <= dl_out[8][0];
         strobe_write_phase <= strobe_phase;
         dq_write_phase <= strobe_phase - memio_pkg::WRITE_PHASE_OFFSET + strobe_cfg_q.dq_out_phase;
      end
   end

endmodule

`default_nettype wire

// [tb/memio_assertions.sv]
// Concurrent bus and reset checks for memio_element.
// Bound onto every memio_element; sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module memio_checker (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic awvalid,
   input wire logic awready,
   input wire logic wvalid,
   input wire logic wready,
   input wire logic bvalid,
   input wire logic bready,
   input wire logic arvalid,
   input wire logic arready,
   input wire logic [4:0] araddr,
   input wire logic rvalid,
   input wire logic rready,
   input wire logic [31:0] rdata,
   input wire logic [1:0] rresp,
   input wire logic [3:0] core_rdata
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   logic bad_q;
   // Remember whether the read in flight hit an unmapped word
   always_ff @(posedge aclk) begin
      if (arvalid && arready) begin
         bad_q <= !(araddr inside {memio_pkg::CTRL_OFS, memio_pkg::SHIFT_OFS, memio_pkg::UPDATE_OFS,
            memio_pkg::IO_APPLIED_OFS, memio_pkg::STROBE_LO_OFS, memio_pkg::STROBE_HI_OFS});
      end
   end
   chk_reset_clear: assert property ($rose(aresetn) |->
      awready && arready && !bvalid && !rvalid && core_rdata == 4'h0) else $error("outputs not clear after reset");
   chk_write_answer: assert property (awvalid && awready && wvalid && wready |-> ##[1:2] bvalid)
      else $error("write not answered");
   chk_read_answer: assert property (arvalid && arready |=> rvalid)
      else $error("read not answered");
   chk_write_busy: assert property (bvalid |-> !awready && !wready)
      else $error("write slot open while answering");
   chk_read_busy: assert property (rvalid |-> !arready)
      else $error("read slot open while answering");
   chk_write_free: assert property (bvalid && bready |=> awready && wready && !bvalid)
      else $error("write slot not freed");
   chk_read_free: assert property (rvalid && rready |=> arready && !rvalid)
      else $error("read slot not freed");
   chk_unmapped_err: assert property (rvalid && bad_q |-> rresp == memio_pkg::RESP_SLVERR && rdata == 32'h0)
      else $error("unmapped read not refused");
   chk_mapped_ok: assert property (rvalid && !bad_q |-> rresp == memio_pkg::RESP_OKAY)
      else $error("mapped read refused");
   cover property (bvalid && bready);
   cover property (rvalid && bad_q);
   cover property ($rose(aresetn));
endmodule
bind memio_element memio_checker memio_checker_inst (.aclk, .aresetn, .awvalid, .awready, .wvalid, .wready,
   .bvalid, .bready, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp, .core_rdata);
`default_nettype wire

// [tb/memory_model.sv]
// Behavioural memory at the pins: random read bits and a strobe.
// Assumes the bench raises drive_en only while a read burst runs.
`timescale 1ns/1ps
`default_nettype none
module memory_model (
   input wire logic aclk,
   input wire logic drive_en,
   output logic pad_rise = 1'b0,
   output logic pad_fall = 1'b0,
   output logic strobe_true = 1'b0,
   output logic strobe_comp = 1'b0
);
   // Released data lines flip so a stale value is never mistaken for data; released strobes drop low
   always @(posedge aclk) begin
      pad_rise <= drive_en ? 1'($urandom) : ~pad_rise;
      pad_fall <= drive_en ? 1'($urandom) : ~pad_fall;
      strobe_true <= drive_en ? ~strobe_true : 1'b0;
      strobe_comp <= drive_en ? strobe_true : 1'b0;
   end
endmodule
`default_nettype wire

// [tb/testbench.sv]
// Self-checking bench: register bus, configuration chains, pin paths.
// Needs memio_pkg, the checker and memory_model compiled first.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic awvalid = 1'b0;
   logic wvalid = 1'b0;
   logic arvalid = 1'b0;
   logic bready = 1'b1;
   logic rready = 1'b1;
   logic drive_en = 1'b0;
   logic core_term_en = 1'b0;
   logic core_strobe_en = 1'b0;
   logic [4:0] awaddr = 5'h00;
   logic [4:0] araddr = 5'h00;
   logic [31:0] wdata = 32'h0;
   logic [3:0] core_wdata = 4'h0;
   logic [3:0] core_oe = 4'h0;
   logic awready, wready, bvalid, arready, rvalid, pad_rise, pad_fall, strobe_true, strobe_comp;
   logic pad_out_rise, pad_out_fall, pad_oe_rise, pad_oe_fall, term_en_out, strobe_en_dly;
   logic [1:0] bresp, rresp, strobe_busout;
   logic [31:0] rdata;
   logic [3:0] core_rdata, dq_write_phase, strobe_write_phase;
   int fails = 0;
   int samples_checked = 0;
   int cycles = 0;

   memio_element memio_element_inst (.aclk, .aresetn, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata,
      .wstrb(4'hf), .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp,
      .pad_rise, .pad_fall, .strobe_true, .strobe_comp, .core_wdata, .core_oe, .core_term_en, .core_strobe_en,
      .core_rdata, .pad_out_rise, .pad_out_fall, .pad_oe_rise, .pad_oe_fall, .term_en_out, .strobe_busout,
      .strobe_en_dly, .dq_write_phase, .strobe_write_phase);
   memory_model memory_model_inst (.aclk, .drive_en, .pad_rise, .pad_fall, .strobe_true, .strobe_comp);

   always #50 aclk = ~aclk;

   // A hung handshake ends the run as a failure
   always @(posedge aclk) begin
      cycles++;
      if (cycles == 20000) begin
         fails++;
         give_verdict();
      end
   end

   task automatic give_verdict();
      if (fails == 0 && samples_checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic cmp(input string n, input logic [45:0] e, input logic [45:0] g);
      samples_checked++;
      if (g !== e) begin
         fails++;
         $display("MISMATCH %s exp %h got %h", n, e, g);
      end
   endtask

   // Address and data go up together and drop as each is taken
   task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready) begin
            awvalid <= 1'b0;
         end
         if (wready) begin
            wvalid <= 1'b0;
         end
      end while (!bvalid);
      cmp("bresp", er, bresp);
   endtask

   task automatic rd_chk(input logic [4:0] a, input logic [31:0] e, input logic [1:0] er);
      araddr <= a;
      arvalid <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready) begin
            arvalid <= 1'b0;
         end
      end while (!rvalid);
      cmp("rdata", e, rdata);
      cmp("rresp", er, rresp);
   endtask

   // Chains take bit 0 first, one bus write per bit
   task automatic shift(input logic sel, input logic [45:0] v, input int n);
      for (int i = 0; i < n; i++) begin
         wr(memio_pkg::SHIFT_OFS, {30'h0, sel, v[i]}, memio_pkg::RESP_OKAY);
      end
   endtask

   function automatic int out_lat(memio_pkg::ctrl_s c, memio_pkg::io_cfg_s io);
      return io.out_delay_one + io.out_delay_two + 3 + c.out_resync_en + c.ddr3_leveling +
         (c.out_mode != memio_pkg::OUT_SDR_COMB);
   endfunction

   function automatic int in_lat(memio_pkg::ctrl_s c, memio_pkg::io_cfg_s io);
      return io.in_delay + 2 + (c.in_ddr_bypass ? 0 : 2) + c.resync_from_leveling + c.resync_levels +
         (c.out_reg_bypass ? 0 : 1);
   endfunction

   function automatic logic [7:0] phases(memio_pkg::strobe_cfg_s s);
      logic [3:0] sp;
      sp = s.strobe_out_phase + (s.strobe_out_phase_inv ? memio_pkg::HALF_TURN : 4'h0);
      return {sp - memio_pkg::WRITE_PHASE_OFFSET + s.dq_out_phase, sp};
   endfunction

   // Random traffic both ways; enable copies data so both paths must agree
   task automatic stream(input memio_pkg::ctrl_s c, input memio_pkg::io_cfg_s io, input memio_pkg::strobe_cfg_s s);
      logic [3:0] wh [80];
      logic [1:0] ph [80];
      logic [1:0] th [80];
      logic [1:0] sh [80];
      logic [1:0] hp;
      int j;
      int lo;
      int li;
      lo = out_lat(c, io);
      li = in_lat(c, io);
      drive_en <= 1'b1;
      for (int u = 0; u < 80; u++) begin
         @(posedge aclk);
         wh[u] = 4'($urandom);
         core_wdata <= wh[u];
         core_oe <= wh[u];
         th[u] = 2'($urandom);
         core_term_en <= th[u][0];
         core_strobe_en <= th[u][1];
         @(negedge aclk);
         ph[u] = {pad_fall, pad_rise};
         sh[u] = {strobe_comp, strobe_true};
         cmp("pad_oe", {pad_oe_fall, pad_oe_rise}, {pad_out_fall, pad_out_rise});
         if (u >= 36 && c.out_mode != memio_pkg::OUT_DDR_HALF) begin
            cmp("pad_out_rise", wh[u - lo][0], pad_out_rise);
         end
         if (u >= 36 && c.out_mode == memio_pkg::OUT_DDR_FULL) begin
            cmp("pad_out_fall", wh[u - lo][1], pad_out_fall);
         end
         // Divider phase restarts on update, so the pair sent follows the cycle parity
         if (u >= 36 && c.out_mode == memio_pkg::OUT_DDR_HALF) begin
            j = u - lo;
            hp = (s.divider_phase ^ j[0]) ? wh[j - 1][3:2] : wh[j][1:0];
            cmp("pad_out_half", hp, {pad_out_fall, pad_out_rise});
         end
         if (u >= 36) begin
            cmp("core_rdata", {2'h0, ph[u - li]}, core_rdata);
            cmp("term_en_out", th[u - s.term_delay_one - s.term_delay_two - 3][0], term_en_out);
            cmp("strobe_en_dly", th[u - s.strobe_en_delay - 2][1], strobe_en_dly);
            cmp("strobe_busout", sh[u - s.busout_delay - 2], strobe_busout);
         end
      end
      @(posedge aclk);
      drive_en <= 1'b0;
   endtask

   initial begin
      memio_pkg::strobe_cfg_s sv;
      memio_pkg::ctrl_s c;
      memio_pkg::io_cfg_s io;
      void'($urandom(32'h66eea8f2));
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd_chk(memio_pkg::CTRL_OFS, 32'h0, memio_pkg::RESP_OKAY);
      rd_chk(memio_pkg::IO_APPLIED_OFS, 32'h0, memio_pkg::RESP_OKAY);
      rd_chk(memio_pkg::STROBE_HI_OFS, 32'h0, memio_pkg::RESP_OKAY);
      rd_chk(5'h18, 32'h0, memio_pkg::RESP_SLVERR);
      wr(5'h1c, 32'hffff_ffff, memio_pkg::RESP_SLVERR);
      sv = 46'({$urandom, $urandom});
      sv.dataout_bypass = 1'b1;
      shift(1'b1, sv, memio_pkg::STROBE_CHAIN_LEN);
      rd_chk(memio_pkg::STROBE_LO_OFS, 32'h0, memio_pkg::RESP_OKAY);
      wr(memio_pkg::UPDATE_OFS, 32'h1, memio_pkg::RESP_OKAY);
      @(negedge aclk);
      cmp("phases", phases(sv), {dq_write_phase, strobe_write_phase});
      @(posedge aclk);
      rd_chk(memio_pkg::STROBE_LO_OFS, sv[31:0], memio_pkg::RESP_OKAY);
      rd_chk(memio_pkg::STROBE_HI_OFS, {18'h0, sv[45:32]}, memio_pkg::RESP_OKAY);
      // Every output mode once, other path settings random except capture strobe mode, held off, and data-out bypass, held on
      for (int k = 0; k < 4; k++) begin
         c = 10'($urandom);
         c.out_mode = memio_pkg::out_mode_e'(k);
         c.capture_strobe_mode = 1'b0;
         io = 11'($urandom);
         wr(memio_pkg::CTRL_OFS, {22'h0, c}, memio_pkg::RESP_OKAY);
         shift(1'b0, {35'h0, io}, memio_pkg::IO_CHAIN_LEN);
         wr(memio_pkg::UPDATE_OFS, 32'h1, memio_pkg::RESP_OKAY);
         rd_chk(memio_pkg::IO_APPLIED_OFS, {21'h0, io}, memio_pkg::RESP_OKAY);
         stream(c, io, sv);
      end
      give_verdict();
   end
endmodule
`default_nettype wire
